// ### hw/shb_frame_classifier.sv
// Purpose: per-frame class decision and sub-band tagging of upper band
// Assumes: coefficients stream from bin 0 of the frame, i_coef_valid
// Notes: frame start is taken only while idle
//Contract
//- onset flag forces transient class directly
//- 288 magnitudes in nine groups of 32
//- sharpness 31*peak over sum minus peak
//- keep per-group largest magnitude
//- gain, average and spread frame figures
//- max sharpness is largest group peak
//- count sharp groups, kappa>4.5, peak>8
//- count noisy groups, kappa below 3
//- harmonic-count threshold from previous class, mode
//- max-sharpness threshold from previous class, mode
//- harmonic test and class counter up/down
//- counter at least 2 also means harmonic
//- noise test else normal
//- two-bit class code
//- store class for next frame
//- upper band starts at offset 6 or 80
//- four or fourteen half-open sub-bands
//- transient boundaries 0,76,152,236,320
//- non-transient fourteen-band boundaries
//- onset indication is one boolean
//- tilt input is crossing sum over root energy
module shb_frame_classifier (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_frame_start,
  input wire logic i_onset_detected_flag,
  input wire logic [15:0] i_tilt,
  input wire logic i_rate_high,
  input wire logic i_ext_swb,
  input wire logic i_coef_valid,
  input wire logic signed [15:0] i_coef,
  output logic o_busy,
  output logic o_class_valid,
  output logic [1:0] o_class,
  output logic [3:0] o_class_counter,
  output logic [15:0] o_max_sharp,
  output logic [3:0] o_sharp_count,
  output logic [3:0] o_noise_count,
  output logic [47:0] o_gain,
  output logic o_sb_valid,
  output logic signed [15:0] o_sb_coef,
  output logic [3:0] o_sb_index,
  output logic [3:0] o_sb_total
);
  shb_classifier_pkg::state_t state_reg;
  logic onset_reg, rate_reg, swb_reg, prev_swb_reg;
  logic [15:0] tilt_reg;
  logic [9:0] bin_reg;
  logic [20:0] grp_sum_reg;
  logic [15:0] grp_peak_reg;
  logic [3:0] grp_reg;
  logic [20:0] sums_reg [9];
  logic [24:0] tot_reg;
  logic [28:0] dev_reg;
  logic [47:0] gain_reg, prev_gain_reg;
  logic [3:0] cnt_reg;
  shb_classifier_pkg::class_t prev_class_reg;
  logic [9:0] offset, k;
  logic in_band, in_cls, grp_end;
  logic [15:0] mag;
  logic [31:0] sq;
  logic [20:0] sum_next, rest;
  logic [15:0] peak_next;
  logic is_sharp, is_noisy;
  logic [24:0] nine_s, dev_term;
  logic [3:0] ish, cnt_next;
  logic [15:0] lsh;
  logic gain_ok, harm_raw, harm, noise;
  shb_classifier_pkg::class_t cls;
  logic [13:0] ge;

  assign offset = rate_reg ? shb_classifier_pkg::OFFSET_HIGH
                           : shb_classifier_pkg::OFFSET_LOW;
  assign k = bin_reg - offset;
  assign in_band = (state_reg == shb_classifier_pkg::ST_COLLECT) && i_coef_valid &&
                   (bin_reg >= offset) && (k <= shb_classifier_pkg::UB_LAST);
  assign in_cls = in_band && (k < shb_classifier_pkg::CLS_LEN);
  assign grp_end = in_cls && (k[4:0] == shb_classifier_pkg::GRP_LAST);
  assign mag = i_coef[15] ? 16'(-i_coef) : 16'(i_coef);
  assign sq = 32'($signed(i_coef) * $signed(i_coef));
  assign sum_next = grp_sum_reg + 21'(mag);
  assign peak_next = (mag > grp_peak_reg) ? mag : grp_peak_reg;
  assign rest = sum_next - 21'(peak_next);
  assign is_sharp = (26'(shb_classifier_pkg::KHI_NUM) * 26'(peak_next) >
                     26'(shb_classifier_pkg::KHI_DEN) * 26'(rest)) &&
                    (peak_next > shb_classifier_pkg::PEAK_MIN);
  // a zero group sum gives zero sharpness, which counts as noisy
  assign is_noisy = (sum_next == 21'h000000) ||
                    (26'(shb_classifier_pkg::KLO_NUM) * 26'(peak_next) <
                     26'(shb_classifier_pkg::KLO_DEN) * 26'(rest));
  assign nine_s = 25'(shb_classifier_pkg::GROUPS) * 25'(sums_reg[grp_reg]);
  assign dev_term = (nine_s > tot_reg) ? nine_s - tot_reg : tot_reg - nine_s;

  always_comb begin
    if (prev_swb_reg) begin
      if (prev_class_reg == shb_classifier_pkg::CLS_HARM) begin
        ish = shb_classifier_pkg::ISH_SWB_HM;
      end else if (prev_class_reg == shb_classifier_pkg::CLS_TRANS) begin
        ish = shb_classifier_pkg::ISH_SWB_TR;
      end else begin
        ish = shb_classifier_pkg::ISH_SWB_OT;
      end
      lsh = shb_classifier_pkg::LSH_SWB;
    end else begin
      ish = (prev_class_reg == shb_classifier_pkg::CLS_HARM) ?
            shb_classifier_pkg::ISH_HM : shb_classifier_pkg::ISH_OT;
      lsh = (prev_class_reg == shb_classifier_pkg::CLS_HARM) ?
            shb_classifier_pkg::LSH_HM : shb_classifier_pkg::LSH_OT;
    end
  end

  // ratio window checked by products, no divider
  assign gain_ok = (prev_gain_reg != 48'h0) &&
    (52'(shb_classifier_pkg::GR_LO) * 52'(gain_reg) > 52'(prev_gain_reg)) &&
    (52'(shb_classifier_pkg::GR_HI_G) * 52'(gain_reg) <
     52'(shb_classifier_pkg::GR_HI_P) * 52'(prev_gain_reg));
  assign harm_raw = (o_sharp_count > ish) && gain_ok && (o_max_sharp > lsh);

  always_comb begin
    cnt_next = cnt_reg;
    if (harm_raw) begin
      if (cnt_reg < shb_classifier_pkg::CNT_MAX) begin
        cnt_next = cnt_reg + 4'h1;
      end
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end

  assign harm = harm_raw || (cnt_next >= shb_classifier_pkg::CNT_HARM);
  assign noise = (o_noise_count > shb_classifier_pkg::NOISE_MIN) &&
    (32'(shb_classifier_pkg::SPR_K) * 32'(dev_reg) <
     32'(shb_classifier_pkg::AVG_K) * 32'(tot_reg)) &&
    (tilt_reg < shb_classifier_pkg::TILT_MAX);

  always_comb begin
    if (onset_reg) begin
      cls = shb_classifier_pkg::CLS_TRANS;
    end else if (harm) begin
      cls = shb_classifier_pkg::CLS_HARM;
    end else if (noise) begin
      cls = shb_classifier_pkg::CLS_NOISE;
    end else begin
      cls = shb_classifier_pkg::CLS_NORMAL;
    end
  end

  // sub-band index is the number of upper boundaries already reached
  for (genvar j = 1; j < 14; j++) begin : g_bound
    if (j < 4) begin : g_both
      assign ge[j] = onset_reg ? (k[8:0] >= shb_classifier_pkg::TR_BOUND[j])
                               : (k[8:0] >= shb_classifier_pkg::NT_BOUND[j]);
    end else begin : g_nt
      assign ge[j] = !onset_reg && (k[8:0] >= shb_classifier_pkg::NT_BOUND[j]);
    end
  end
  assign ge[0] = 1'b0;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= shb_classifier_pkg::ST_IDLE;
      grp_reg <= 4'h0;
    end else begin
      case (state_reg)
        shb_classifier_pkg::ST_IDLE: begin
          if (i_frame_start) begin
            state_reg <= shb_classifier_pkg::ST_COLLECT;
          end
        end
        shb_classifier_pkg::ST_COLLECT: begin
          grp_reg <= 4'h0;
          if (in_band && k == shb_classifier_pkg::UB_LAST) begin
            state_reg <= shb_classifier_pkg::ST_SPREAD;
          end
        end
        shb_classifier_pkg::ST_SPREAD: begin
          grp_reg <= grp_reg + 4'h1;
          if (grp_reg == shb_classifier_pkg::GRP_LAST_IDX) begin
            state_reg <= shb_classifier_pkg::ST_DECIDE;
          end
        end
        default: begin
          state_reg <= shb_classifier_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      onset_reg <= 1'b0;
      rate_reg <= 1'b0;
      swb_reg <= 1'b0;
      tilt_reg <= 16'h0000;
      bin_reg <= 10'h000;
    end else if (state_reg == shb_classifier_pkg::ST_IDLE && i_frame_start) begin
      onset_reg <= i_onset_detected_flag;
      rate_reg <= i_rate_high;
      swb_reg <= i_ext_swb;
      tilt_reg <= i_tilt;
      bin_reg <= 10'h000;
    end else if (state_reg == shb_classifier_pkg::ST_COLLECT && i_coef_valid) begin
      bin_reg <= bin_reg + 10'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      grp_sum_reg <= 21'h000000;
      grp_peak_reg <= 16'h0000;
      tot_reg <= 25'h0000000;
      gain_reg <= 48'h0;
      o_max_sharp <= 16'h0000;
      o_sharp_count <= 4'h0;
      o_noise_count <= 4'h0;
    end else if (state_reg == shb_classifier_pkg::ST_IDLE && i_frame_start) begin
      grp_sum_reg <= 21'h000000;
      grp_peak_reg <= 16'h0000;
      tot_reg <= 25'h0000000;
      gain_reg <= 48'h0;
      o_max_sharp <= 16'h0000;
      o_sharp_count <= 4'h0;
      o_noise_count <= 4'h0;
    end else if (in_band) begin
      gain_reg <= gain_reg + 48'(sq);
      if (in_cls) begin
        tot_reg <= tot_reg + 25'(mag);
        grp_sum_reg <= grp_end ? 21'h000000 : sum_next;
        grp_peak_reg <= grp_end ? 16'h0000 : peak_next;
      end
      if (grp_end) begin
        if (peak_next > o_max_sharp) begin
          o_max_sharp <= peak_next;
        end
        o_sharp_count <= o_sharp_count + 4'(is_sharp);
        o_noise_count <= o_noise_count + 4'(is_noisy);
      end
    end
  end

  for (genvar g = 0; g < 9; g++) begin : g_sums
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        sums_reg[g] <= 21'h000000;
      end else if (grp_end && k[8:5] == 4'(g)) begin
        sums_reg[g] <= sum_next;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dev_reg <= 29'h00000000;
    end else if (state_reg == shb_classifier_pkg::ST_COLLECT) begin
      dev_reg <= 29'h00000000;
    end else if (state_reg == shb_classifier_pkg::ST_SPREAD) begin
      dev_reg <= dev_reg + 29'(dev_term);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= 4'h0;
      prev_gain_reg <= 48'h0;
      prev_swb_reg <= 1'b0;
      prev_class_reg <= shb_classifier_pkg::CLS_NORMAL;
      o_class <= 2'b00;
      o_class_valid <= 1'b0;
    end else begin
      o_class_valid <= state_reg == shb_classifier_pkg::ST_DECIDE;
      if (state_reg == shb_classifier_pkg::ST_DECIDE) begin
        if (!onset_reg) begin
          cnt_reg <= cnt_next;
        end
        prev_gain_reg <= gain_reg;
        prev_swb_reg <= swb_reg;
        prev_class_reg <= cls;
        o_class <= cls;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
      o_sb_valid <= 1'b0;
      o_sb_coef <= 16'sh0000;
      o_sb_index <= 4'h0;
      o_sb_total <= shb_classifier_pkg::SB_NT;
    end else begin
      o_busy <= !(state_reg == shb_classifier_pkg::ST_IDLE && !i_frame_start) &&
                state_reg != shb_classifier_pkg::ST_DECIDE;
      o_sb_valid <= in_band;
      o_sb_coef <= i_coef;
      o_sb_index <= 4'($countones(ge));
      o_sb_total <= onset_reg ? shb_classifier_pkg::SB_TR : shb_classifier_pkg::SB_NT;
    end
  end

  assign o_class_counter = cnt_reg;
  assign o_gain = gain_reg;

  sequence s_spread_run;
    (state_reg == shb_classifier_pkg::ST_SPREAD)[*8] ##1
    (state_reg == shb_classifier_pkg::ST_SPREAD) ##1
    (state_reg == shb_classifier_pkg::ST_DECIDE);
  endsequence
  property p_spread_len;
    @(posedge i_clk) disable iff (!i_nrst)
    $rose(state_reg == shb_classifier_pkg::ST_SPREAD) |-> s_spread_run;
  endproperty
  a_spread_len: assert property (p_spread_len) else $error("spread pass not 9 cycles");
  property p_onset;
    @(posedge i_clk) disable iff (!i_nrst)
    state_reg == shb_classifier_pkg::ST_DECIDE && onset_reg |=>
      o_class_valid && o_class == 2'b01;
  endproperty
  a_onset: assert property (p_onset) else $error("onset frame not transient");
  property p_prev_class;
    @(posedge i_clk) disable iff (!i_nrst)
    o_class_valid |-> prev_class_reg == o_class;
  endproperty
  a_prev_class: assert property (p_prev_class) else $error("class not kept");
  property p_cnt_up;
    @(posedge i_clk) disable iff (!i_nrst)
    state_reg == shb_classifier_pkg::ST_DECIDE && !onset_reg && harm_raw && cnt_reg < 4'hC
      |=> cnt_reg == $past(cnt_reg) + 4'h1;
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("class counter not raised");
  property p_cnt_harm;
    @(posedge i_clk) disable iff (!i_nrst)
    o_class_valid && !onset_reg && cnt_reg >= 4'h2 |-> o_class == 2'b11;
  endproperty
  a_cnt_harm: assert property (p_cnt_harm) else $error("counter harmonic missed");
  property p_noise;
    @(posedge i_clk) disable iff (!i_nrst)
    o_class_valid && o_class == 2'b00 |-> o_noise_count > 4'h4 && tilt_reg < 16'h0500;
  endproperty
  a_noise: assert property (p_noise) else $error("noise class without cause");
  property p_count_clear;
    @(posedge i_clk) disable iff (!i_nrst)
    state_reg == shb_classifier_pkg::ST_IDLE && i_frame_start |=>
      o_sharp_count == 4'h0 && o_noise_count == 4'h0;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("counts not cleared");
  property p_tr_bands;
    @(posedge i_clk) disable iff (!i_nrst)
    o_sb_valid && onset_reg |-> o_sb_index < 4'h4 && o_sb_total == 4'h4;
  endproperty
  a_tr_bands: assert property (p_tr_bands) else $error("transient band out of range");
  property p_pass;
    @(posedge i_clk) disable iff (!i_nrst)
    in_band |=> o_sb_valid && o_sb_coef == $past(i_coef);
  endproperty
  a_pass: assert property (p_pass) else $error("upper band coefficient lost");
endmodule : shb_frame_classifier

// ### hw/shb_classifier_pkg.sv
// Purpose: constants and types of the upper-band frame classifier
// Assumes: 16-bit signed transform coefficients, one per valid cycle
// Notes: ratios are held as integer numerator/denominator pairs
package shb_classifier_pkg;
  localparam logic [9:0] OFFSET_LOW = 10'h006;
  localparam logic [9:0] OFFSET_HIGH = 10'h050;
  localparam logic [9:0] UB_LAST = 10'h13F;
  localparam logic [9:0] CLS_LEN = 10'h120;
  localparam logic [4:0] GRP_LAST = 5'h1F;
  localparam logic [3:0] GRP_LAST_IDX = 4'h8;
  localparam logic [4:0] GROUPS = 5'h09;
  // kappa > 4.5 as 62*peak > 9*rest, kappa < 3 as 31*peak < 3*rest
  localparam logic [5:0] KHI_NUM = 6'h3E;
  localparam logic [4:0] KHI_DEN = 5'h09;
  localparam logic [5:0] KLO_NUM = 6'h1F;
  localparam logic [4:0] KLO_DEN = 5'h03;
  localparam logic [15:0] PEAK_MIN = 16'h0008;
  localparam logic [3:0] ISH_SWB_HM = 4'h4;
  localparam logic [3:0] ISH_SWB_TR = 4'h8;
  localparam logic [3:0] ISH_SWB_OT = 4'h6;
  localparam logic [3:0] ISH_HM = 4'h2;
  localparam logic [3:0] ISH_OT = 4'h8;
  localparam logic [15:0] LSH_SWB = 16'h000A;
  localparam logic [15:0] LSH_HM = 16'h0005;
  localparam logic [15:0] LSH_OT = 16'h0014;
  localparam logic [3:0] CNT_MAX = 4'hC;
  localparam logic [3:0] CNT_HARM = 4'h2;
  // 0.5 < g/gp < 1.8 as 2g > gp and 5g < 9gp
  localparam logic [3:0] GR_LO = 4'h2;
  localparam logic [3:0] GR_HI_G = 4'h5;
  localparam logic [3:0] GR_HI_P = 4'h9;
  localparam logic [3:0] NOISE_MIN = 4'h4;
  // spread < 4.8*avg as 5*sum|9*s - T| < 24*T
  localparam logic [3:0] SPR_K = 4'h5;
  localparam logic [4:0] AVG_K = 5'h18;
  localparam logic [15:0] TILT_MAX = 16'h0500;
  localparam logic [3:0] SB_TR = 4'h4;
  localparam logic [3:0] SB_NT = 4'hE;
  localparam logic [8:0] TR_BOUND [4] = '{9'h000, 9'h04C, 9'h098, 9'h0EC};
  localparam logic [8:0] NT_BOUND [14] = '{9'h000, 9'h010, 9'h028, 9'h038,
    9'h050, 9'h060, 9'h078, 9'h088, 9'h0A0, 9'h0B8, 9'h0D0, 9'h0E8,
    9'h100, 9'h120};
  typedef enum logic [1:0] {
    CLS_NOISE = 2'b00,
    CLS_TRANS = 2'b01,
    CLS_NORMAL = 2'b10,
    CLS_HARM = 2'b11
  } class_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_COLLECT = 4'b0010,
    ST_SPREAD = 4'b0100,
    ST_DECIDE = 4'b1000
  } state_t;
endpackage : shb_classifier_pkg

// ### tb/coef_source.sv
// Purpose: upstream transform stage model streaming one frame spectrum
// Assumes: bench fills spec before raising i_go
// Notes: stalls at random when i_slow, idle data is inverted
module coef_source (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_go,
  input wire logic i_slow,
  input wire logic [9:0] i_count,
  output logic o_valid,
  output logic signed [15:0] o_coef
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] spec [512];
  logic run = 1'b0;
  logic go_s;
  int idx = 0;
  int seed = 32'h6e8b;
  initial begin
    o_valid = 1'b0;
    o_coef = 16'sh0000;
  end
  always @(posedge i_clk) begin
    go_s = i_go;
    #1;
    if (!i_nrst) begin
      run = 1'b0;
    end else if (go_s) begin
      run = 1'b1;
      idx = 0;
    end
    if (run && (!i_slow || ($random(seed) & 3) != 0)) begin
      o_valid = 1'b1;
      o_coef = spec[idx];
      idx++;
      if (idx == int'(i_count)) begin
        run = 1'b0;
      end
    end else begin
      o_valid = 1'b0;
      // idle cycles invert the bus, so the last bin returns every second idle cycle
      o_coef = ~o_coef;
    end
  end
endmodule : coef_source

// ### tb/shb_frame_classifier_tb_top.sv
// Purpose: self-checking bench of the upper-band frame classifier
// Assumes: coef_source streams offset plus 324 bins per frame
// Notes: predict mirrors the class decision from the frame spectrum
module shb_frame_classifier_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic frame_start = 1'b0;
  logic onset = 1'b0;
  logic rate_high = 1'b0;
  logic ext_swb = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [15:0] tilt = 16'h0000;
  logic coef_valid;
  logic signed [15:0] coef;
  logic busy, class_valid, sb_valid;
  logic [1:0] cls;
  logic [3:0] class_counter, sharp_count, noise_count, sb_index, sb_total;
  logic [15:0] max_sharp;
  logic [47:0] gain;
  logic signed [15:0] sb_coef;
  int errors = 0;
  int check_count = 0;
  int seed = 32'h6e8b;
  int k_seen = 0;
  int cur_off = 6;
  logic cur_tr = 1'b0;
  logic [1:0] prev_cls = 2'b10;
  logic prev_swb = 1'b0;
  longint prev_gain = 0;
  int cnt = 0;
  int tr_b[4] = '{0, 76, 152, 236};
  int nt_b[14] = '{0, 16, 40, 56, 80, 96, 120, 136, 160, 184, 208, 232, 256, 288};

  always #12.5 i_clk = ~i_clk;

  shb_frame_classifier u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_frame_start(frame_start),
    .i_onset_detected_flag(onset), .i_tilt(tilt), .i_rate_high(rate_high),
    .i_ext_swb(ext_swb), .i_coef_valid(coef_valid), .i_coef(coef), .o_busy(busy),
    .o_class_valid(class_valid), .o_class(cls), .o_class_counter(class_counter),
    .o_max_sharp(max_sharp), .o_sharp_count(sharp_count), .o_noise_count(noise_count),
    .o_gain(gain), .o_sb_valid(sb_valid), .o_sb_coef(sb_coef), .o_sb_index(sb_index),
    .o_sb_total(sb_total));
  coef_source u_src (.i_clk(i_clk), .i_nrst(i_nrst), .i_go(go), .i_slow(slow),
    .i_count(10'(cur_off + 324)), .o_valid(coef_valid), .o_coef(coef));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_val(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_cls(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t class got %h exp %h", $time, got, exp);
    end
  endtask : check_cls

  function automatic logic [3:0] band_of(int k, logic tr);
    logic [3:0] b;
    b = 4'h0;
    for (int j = 1; j < 14; j++) begin
      if (tr ? (j < 4 && k >= tr_b[j]) : (k >= nt_b[j])) begin
        b = 4'(j);
      end
    end
    return b;
  endfunction : band_of

  always @(negedge i_clk) begin
    if (sb_valid === 1'b1) begin
      check_val(48'(sb_coef), 48'(u_src.spec[cur_off + k_seen]));
      check_val(48'(sb_index), 48'(band_of(k_seen, cur_tr)));
      check_val(48'(sb_total), cur_tr ? 48'h4 : 48'hE);
      k_seen++;
    end
  end

  task automatic fill(int mode);
    for (int i = 0; i < 512; i++) begin
      case (mode)
        0: u_src.spec[i] = 16'($random(seed) % 2000);
        1: u_src.spec[i] = (i % 32 == 7) ? 16'sh0384 : 16'($random(seed) % 2);
        2: u_src.spec[i] = ($random(seed) & 1) ? 16'sh0005 : 16'shFFFB;
        default: u_src.spec[i] = 16'sh0000;
      endcase
    end
  endtask : fill

  task automatic predict();
    int s[9];
    int p[9];
    int m, t, spr, r, ish, lsh, e_max, sc, nc;
    longint g, v;
    logic harm;
    logic [1:0] e;
    s = '{default: 0};
    p = '{default: 0};
    g = 0;
    t = 0;
    spr = 0;
    e_max = 0;
    sc = 0;
    nc = 0;
    for (int k = 0; k < 320; k++) begin
      v = u_src.spec[cur_off + k];
      g += v * v;
      m = int'((v < 0) ? -v : v);
      if (k < 288) begin
        p[k / 32] = (m > p[k / 32]) ? m : p[k / 32];
        s[k / 32] += m;
      end
    end
    for (int j = 0; j < 9; j++) begin
      t += s[j];
      r = s[j] - p[j];
      sc += (s[j] != 0 && 62 * p[j] > 9 * r && p[j] > 8) ? 1 : 0;
      nc += (s[j] == 0 || 31 * p[j] < 3 * r) ? 1 : 0;
      e_max = (p[j] > e_max) ? p[j] : e_max;
    end
    for (int j = 0; j < 9; j++) begin
      spr += (9 * s[j] > t) ? 9 * s[j] - t : t - 9 * s[j];
    end
    ish = prev_swb ? (prev_cls == 2'b11 ? 4 : prev_cls == 2'b01 ? 8 : 6)
                   : (prev_cls == 2'b11 ? 2 : 8);
    lsh = prev_swb ? 10 : (prev_cls == 2'b11 ? 5 : 20);
    harm = sc > ish && prev_gain != 0 && 2 * g > prev_gain && 5 * g < 9 * prev_gain && e_max > lsh;
    if (cur_tr) begin
      e = 2'b01;
    end else begin
      cnt = harm ? ((cnt < 12) ? cnt + 1 : cnt) : ((cnt > 0) ? cnt - 1 : cnt);
      e = (harm || cnt >= 2) ? 2'b11 : (nc > 4 && 5 * spr < 24 * t && tilt < 16'h0500) ? 2'b00 : 2'b10;
    end
    check_cls(cls, e);
    check_val(48'(class_counter), 48'(cnt));
    check_val(gain, 48'(g));
    check_val(48'(max_sharp), 48'(e_max));
    check_val(48'(sharp_count), 48'(sc));
    check_val(48'(noise_count), 48'(nc));
    check_val(48'(k_seen), 48'h140);
    check_val(48'(busy), 48'h0);
    prev_cls = e;
    prev_swb = ext_swb;
    prev_gain = g;
  endtask : predict

  task automatic run_frame(int mode, logic tr, logic rate, logic swb, logic [15:0] tl);
    int n;
    fill(mode);
    @(posedge i_clk);
    #1;
    frame_start = 1'b1;
    onset = tr;
    rate_high = rate;
    ext_swb = swb;
    tilt = tl;
    go = 1'b1;
    slow = 1'($random(seed));
    cur_off = rate ? 80 : 6;
    cur_tr = tr;
    k_seen = 0;
    @(posedge i_clk);
    #1;
    frame_start = 1'b0;
    go = 1'b0;
    // a start while busy must be ignored
    repeat (20) @(posedge i_clk);
    #1;
    check_val(48'(busy), 48'h1);
    frame_start = 1'b1;
    @(posedge i_clk);
    #1;
    frame_start = 1'b0;
    n = 0;
    while (class_valid !== 1'b1 && n < 3000) begin
      @(posedge i_clk);
      #2;
      n++;
    end
    if (n == 3000) begin
      errors++;
    end
    predict();
  endtask : run_frame

  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    check_val(48'(sb_total), 48'hE);
    run_frame(3, 1'b0, 1'b0, 1'b0, 16'h0000);
    run_frame(2, 1'b0, 1'b0, 1'b0, 16'h0100);
    run_frame(2, 1'b0, 1'b1, 1'b0, 16'h0500);
    for (int i = 0; i < 16; i++) begin
      run_frame(1, i == 3, i[0], i[1], 16'h0000);
    end
    // mid-run reset clears the carried frame state
    @(posedge i_clk);
    #1;
    i_nrst = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    prev_cls = 2'b10;
    prev_swb = 1'b0;
    prev_gain = 0;
    cnt = 0;
    check_val(48'(class_counter), 48'h0);
    check_cls(cls, 2'b00);
    for (int i = 0; i < 4; i++) begin
      run_frame(2, 1'b0, 1'b1, 1'b1, 16'h0000);
    end
    for (int i = 0; i < 12; i++) begin
      run_frame(int'($random(seed) & 3), ($random(seed) & 3) == 0, 1'($random(seed)),
        1'($random(seed)), 16'($random(seed) & 16'h07FF));
    end
    report_and_stop();
  end

  initial begin
    #1500000;
    errors++;
    report_and_stop();
  end
endmodule : shb_frame_classifier_tb_top
